// >>> rtl/cpm_delay_mem.sv
// Purpose: Ring memory holding past frame samples for group delay matching.
// Assumes: One write per frame at most; a read on every clock.
// Notes: Read data come from a register, one cycle after the address.
module cpm_delay_mem #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = 4
) (
  input wire logic aclk, // Clock
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write address
  input wire logic [WIDTH-1:0] wr_data, // Write data
  input wire logic [AW-1:0] rd_addr, // Read address
  output logic [WIDTH-1:0] rd_data // Registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// >>> rtl/cpm_pkg.sv
// Purpose: Shared constants for the call-progress monitor output block.
// Assumes: 40 MHz aclk, 8 kHz frame sync, 16-bit two's complement samples.
// Notes: Register indices are word indices; byte address is four times the index.
package cpm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FRAME_HZ = 8_000;
  localparam int unsigned PWM_HZ = 32_000;
  localparam int unsigned PWM_PERIOD = CLK_HZ / PWM_HZ;
  localparam int unsigned PWM_CNT_W = 11;

  // Filter group delays in whole frames; 1.6 sample periods rounds up to 2
  localparam logic [3:0] GD_FIR_FRAMES = 4'hc;
  localparam logic [3:0] GD_IIR_FRAMES = 4'h2;

  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned ATT_W = 8;
  localparam int unsigned ATT_SHIFT = 8;

  // Register word indices
  localparam logic [5:0] IDX_CTRL1 = 6'h01;
  localparam logic [5:0] IDX_CTRL2 = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_RX_ATT = 6'h14;
  localparam logic [5:0] IDX_TX_ATT = 6'h15;

  // Control 1 fields
  localparam int unsigned C1_IIR_SEL = 0;
  localparam int unsigned C1_TRISTATE = 1;
  localparam int unsigned C1_TONE_EN = 3;
  localparam int unsigned C1_MODE_LO = 4;
  localparam int unsigned C1_MODE_HI = 5;
  // Control 2 fields
  localparam int unsigned C2_INT_EN = 7;
  // Status fields
  localparam int unsigned ST_MON = 0;
  localparam int unsigned ST_TXOE = 1;
  localparam int unsigned ST_IIR = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ATT_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CPM_MODE_RZ_PWM,
    CPM_MODE_DSIGMA,
    CPM_MODE_BAL_PWM,
    CPM_MODE_RSVD
  } cpm_mode_t;
endpackage

// >>> rtl/cpm_top.sv
// Purpose: Call-progress monitor output with AXI4-Lite control registers.
// Assumes: Inputs synchronous to aclk; frame_sync rises once per frame.
// Notes: Line samples pass unchanged; only the monitor path is attenuated.
// Contract
// - Transmit data output releases at a bit clock falling edge when tri-state chosen.
// - FIR option: 8 kHz rate, 12 sample group delay matched.
// - IIR option: about 1.6 sample group delay matched.
// - Receive and transmit monitor contributions scale linearly by their attenuation registers.
// - Attenuation of zero mutes that path on the monitor output.
// - Attenuation never alters samples sent to or received from the line.
// - Mode field bits 5:4 select delta-sigma, 32 kHz RZ or balanced PWM.
module cpm_top (
  input wire logic aclk, // Clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic frame_sync, // 8 kHz frame sync
  input wire logic bit_clock, // Bit clock, sampled
  input wire logic [15:0] rx_sample, // Sample received from the line
  input wire logic [15:0] tx_sample, // Sample to transmit to the line
  output logic [15:0] rx_line_out, // Received sample, unchanged
  output logic [15:0] tx_line_out, // Transmit sample, unchanged
  output logic transmit_data_out, // Serial transmit data
  output logic transmit_data_oe, // Transmit data output enable
  output logic monitor_analog_out // Pulse-modulated monitor output
);
  localparam int unsigned SW = cpm_pkg::SAMPLE_W;

  // Register file and bus state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, rx_att_q, rx_att_d, tx_att_q, tx_att_d;

  // Datapath state
  logic fs_prev_q, bclk_prev_q, tick_d1_q;
  logic [3:0] wptr_q, wptr_d, rd_addr;
  logic [31:0] mem_rd;
  logic signed [SW-1:0] mix_q, mix_d;
  logic [cpm_pkg::PWM_CNT_W-1:0] duty_q, duty_d, pcnt_q, pcnt_d;
  logic [SW:0] acc_q, acc_d;
  logic mon_q, mon_d;
  logic [15:0] rxl_q, rxl_d, txl_q, txl_d, sh_q, sh_d;
  logic [4:0] bits_q, bits_d;
  logic tdo_q, tdo_d, toe_q, toe_d;

  logic frame_tick, bclk_rise, bclk_fall, mon_active;
  cpm_pkg::cpm_mode_t mode;

  function automatic logic signed [SW:0] scale(input logic signed [SW-1:0] s,
                                               input logic [7:0] att);
    logic signed [SW+8:0] p;
    p = s * $signed({1'b0, att});
    return p[SW+8:cpm_pkg::ATT_SHIFT];
  endfunction

  function automatic logic [31:0] read_reg(input logic [5:0] idx, input logic [7:0] c1,
                                           input logic [7:0] c2, input logic [7:0] ra,
                                           input logic [7:0] ta, input logic [7:0] st);
    case (idx)
      cpm_pkg::IDX_CTRL1: read_reg = {24'h000000, c1};
      cpm_pkg::IDX_CTRL2: read_reg = {24'h000000, c2};
      cpm_pkg::IDX_STATUS: read_reg = {24'h000000, st};
      cpm_pkg::IDX_RX_ATT: read_reg = {24'h000000, ra};
      cpm_pkg::IDX_TX_ATT: read_reg = {24'h000000, ta};
      default: read_reg = 32'h00000000;
    endcase
  endfunction

  function automatic logic idx_ok(input logic [5:0] idx);
    return idx == cpm_pkg::IDX_CTRL1 || idx == cpm_pkg::IDX_CTRL2 ||
           idx == cpm_pkg::IDX_STATUS || idx == cpm_pkg::IDX_RX_ATT ||
           idx == cpm_pkg::IDX_TX_ATT;
  endfunction

  assign mode = cpm_pkg::cpm_mode_t'(ctrl1_q[cpm_pkg::C1_MODE_HI:cpm_pkg::C1_MODE_LO]);
  assign mon_active = ctrl1_q[cpm_pkg::C1_TONE_EN] && !ctrl2_q[cpm_pkg::C2_INT_EN];
  assign frame_tick = frame_sync && !fs_prev_q;
  assign bclk_rise = bit_clock && !bclk_prev_q;
  assign bclk_fall = !bit_clock && bclk_prev_q;

  always_comb begin
    logic [7:0] st;
    st = {5'h00, ctrl1_q[cpm_pkg::C1_IIR_SEL], toe_q, mon_q};
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    rx_att_d = rx_att_q;
    tx_att_d = tx_att_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = idx_ok(awaddr_q[7:2]) ? cpm_pkg::RESP_OKAY : cpm_pkg::RESP_SLVERR;
      if (wstrb0_q) begin
        case (awaddr_q[7:2])
          cpm_pkg::IDX_CTRL1: ctrl1_d = wdata_q[7:0];
          cpm_pkg::IDX_CTRL2: ctrl2_d = wdata_q[7:0];
          cpm_pkg::IDX_RX_ATT: rx_att_d = wdata_q[7:0];
          cpm_pkg::IDX_TX_ATT: tx_att_d = wdata_q[7:0];
          default: ;
        endcase
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = read_reg(s_axi_araddr[7:2], ctrl1_q, ctrl2_q, rx_att_q, tx_att_q, st);
      rresp_d = idx_ok(s_axi_araddr[7:2]) ? cpm_pkg::RESP_OKAY : cpm_pkg::RESP_SLVERR;
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cpm_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= cpm_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl1_q <= cpm_pkg::CTRL_RESET;
      ctrl2_q <= cpm_pkg::CTRL_RESET;
      rx_att_q <= cpm_pkg::ATT_RESET;
      tx_att_q <= cpm_pkg::ATT_RESET;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      rx_att_q <= rx_att_d;
      tx_att_q <= tx_att_d;
    end
  end

  // Monitor samples are delayed to line up with the selected voice filter
  assign rd_addr = wptr_q - (ctrl1_q[cpm_pkg::C1_IIR_SEL] ?
                             cpm_pkg::GD_IIR_FRAMES : cpm_pkg::GD_FIR_FRAMES);

  cpm_delay_mem #(.WIDTH(32), .DEPTH(16), .AW(4)) u_mem (
    .aclk(aclk),
    .wr_en(frame_tick),
    .wr_addr(wptr_q),
    .wr_data({rx_sample, tx_sample}),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  always_comb begin
    logic signed [SW+1:0] sum;
    logic [SW-1:0] u;
    logic [SW+cpm_pkg::PWM_CNT_W-1:0] prod;
    logic [cpm_pkg::PWM_CNT_W-1:0] half;
    sum = scale(mem_rd[31:16], rx_att_q) + scale(mem_rd[15:0], tx_att_q);
    u = {~mix_q[SW-1], mix_q[SW-2:0]};
    prod = u * cpm_pkg::PWM_PERIOD[cpm_pkg::PWM_CNT_W-1:0];
    half = duty_q >> 1;
    wptr_d = frame_tick ? wptr_q + 4'h1 : wptr_q;
    mix_d = mix_q;
    if (tick_d1_q) begin
      // Linear scaling; zero attenuation gives a zero product
      if (sum > $signed(18'h07fff)) begin
        mix_d = 16'sh7fff;
      end else if (sum < $signed(18'h38000)) begin
        mix_d = -16'sh8000;
      end else begin
        mix_d = sum[SW-1:0];
      end
    end
    duty_d = prod[SW+cpm_pkg::PWM_CNT_W-1:SW];
    pcnt_d = (pcnt_q == cpm_pkg::PWM_PERIOD[cpm_pkg::PWM_CNT_W-1:0] - 11'h001) ?
             11'h000 : pcnt_q + 11'h001;
    acc_d = 17'h00000;
    if (mon_active && mode == cpm_pkg::CPM_MODE_DSIGMA) begin
      // Integrator runs only in its own format, so no stale or unknown state carries over
      acc_d = {1'b0, acc_q[SW-1:0]} + {1'b0, u};
    end
    mon_d = 1'b0;
    if (mon_active) begin
      case (mode)
        cpm_pkg::CPM_MODE_RZ_PWM: mon_d = pcnt_q < duty_q;
        cpm_pkg::CPM_MODE_DSIGMA: mon_d = acc_q[SW];
        cpm_pkg::CPM_MODE_BAL_PWM: mon_d = pcnt_q < half ||
          pcnt_q >= cpm_pkg::PWM_PERIOD[cpm_pkg::PWM_CNT_W-1:0] - (duty_q - half);
        default: mon_d = 1'b0;
      endcase
    end
    // Line samples bypass the attenuators entirely
    rxl_d = frame_tick ? rx_sample : rxl_q;
    txl_d = frame_tick ? tx_sample : txl_q;
    sh_d = sh_q;
    bits_d = bits_q;
    tdo_d = tdo_q;
    toe_d = toe_q;
    if (frame_tick) begin
      sh_d = tx_sample;
      bits_d = 5'(cpm_pkg::SAMPLE_W);
      toe_d = 1'b1;
    end else if (bclk_rise && bits_q != 5'h00) begin
      tdo_d = sh_q[SW-1];
      sh_d = {sh_q[SW-2:0], 1'b0};
      bits_d = bits_q - 5'h01;
    end else if (bclk_fall && bits_q == 5'h00 && ctrl1_q[cpm_pkg::C1_TRISTATE]) begin
      toe_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fs_prev_q <= 1'b0;
      bclk_prev_q <= 1'b0;
      tick_d1_q <= 1'b0;
      wptr_q <= 4'h0;
      mix_q <= 16'sh0000;
      duty_q <= 11'h000;
      pcnt_q <= 11'h000;
      acc_q <= 17'h00000;
      mon_q <= 1'b0;
      rxl_q <= 16'h0000;
      txl_q <= 16'h0000;
      sh_q <= 16'h0000;
      bits_q <= 5'h00;
      tdo_q <= 1'b0;
      toe_q <= 1'b0;
    end else begin
      fs_prev_q <= frame_sync;
      bclk_prev_q <= bit_clock;
      tick_d1_q <= frame_tick;
      wptr_q <= wptr_d;
      mix_q <= mix_d;
      duty_q <= duty_d;
      pcnt_q <= pcnt_d;
      acc_q <= acc_d;
      mon_q <= mon_d;
      rxl_q <= rxl_d;
      txl_q <= txl_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      tdo_q <= tdo_d;
      toe_q <= toe_d;
    end
  end

  assign rx_line_out = rxl_q;
  assign tx_line_out = txl_q;
  assign transmit_data_out = tdo_q;
  assign transmit_data_oe = toe_q;
  assign monitor_analog_out = mon_q;

  sequence mute_both_s;
    tick_d1_q && rx_att_q == 8'h00 && tx_att_q == 8'h00;
  endsequence

  sequence tick_s;
    frame_tick ##1 tick_d1_q;
  endsequence

  tristate_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(toe_q) |-> $past(bclk_fall) && ctrl1_q[cpm_pkg::C1_TRISTATE])
    else $error("output released off a bit clock falling edge");
  fir_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl1_q[cpm_pkg::C1_IIR_SEL] |-> rd_addr == wptr_q - 4'hc)
    else $error("fir delay not twelve frames");
  iir_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl1_q[cpm_pkg::C1_IIR_SEL] |-> rd_addr == wptr_q - 4'h2)
    else $error("iir delay not two frames");
  scale_mix_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_s ##0 (rx_att_q == 8'h00) |-> ##1 mix_q == $past(scale(mem_rd[15:0], tx_att_q)) ||
      mix_q == 16'sh7fff || mix_q == -16'sh8000)
    else $error("monitor mix not scaled by transmit attenuation");
  mute_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mute_both_s |=> mix_q == 16'sh0000)
    else $error("zero attenuation did not mute");
  line_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_tick |=> rx_line_out == $past(rx_sample) && tx_line_out == $past(tx_sample))
    else $error("line sample altered");
  rz_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mon_active && mode == cpm_pkg::CPM_MODE_RZ_PWM && pcnt_q >= duty_q
      && $stable(ctrl1_q) |=> !mon_q)
    else $error("rz pwm high past its duty");
  rsvd_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == cpm_pkg::CPM_MODE_RSVD) [*2] |-> !mon_q)
    else $error("reserved mode output not low");
endmodule

// >>> verif/cpm_spk_model.sv
// Purpose: Speaker driver and call-progress listener on the monitor output.
// Assumes: Monitor output is a registered level on aclk.
// Notes: The listener only hears average drive, so every format reduces to a count.
module cpm_spk_model (
  input wire logic aclk, // Clock
  input wire logic clr, // Starts a new listening window
  input wire logic drive, // Monitor output from the device
  output logic [15:0] hi_cnt // High cycles since the window opened
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  always_comb begin
    cnt_d = clr ? 16'h0000 : cnt_q + {15'h0000, drive};
  end
  always_ff @(posedge aclk) begin
    cnt_q <= cnt_d;
  end
  assign hi_cnt = cnt_q;
endmodule

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the call-progress monitor output.
// Assumes: 40 MHz aclk, one frame every 5000 clocks, 16 bit clock rises a frame.
// Notes: Filter delays are judged by comparing average drive between frames.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_C1 = {cpm_pkg::IDX_CTRL1, 2'b00};
  localparam logic [7:0] A_C2 = {cpm_pkg::IDX_CTRL2, 2'b00};
  localparam logic [7:0] A_RX = {cpm_pkg::IDX_RX_ATT, 2'b00};
  localparam logic [7:0] A_TX = {cpm_pkg::IDX_TX_ATT, 2'b00};
  localparam logic [7:0] A_ST = {cpm_pkg::IDX_STATUS, 2'b00};
  localparam logic [15:0] KA = 16'h3000;
  // High cycles are counted from the clear at cycle 10 to the read at cycle 4900
  localparam int WIN = 4889;
  // Mid-scale gives half density; a PWM window may cut up to a quarter period off
  localparam int BAL_TOL = cpm_pkg::PWM_PERIOD / 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic frame_sync = 1'b0, bit_clock = 1'b0, run = 1'b0, clr = 1'b0, tri_q = 1'b0;
  logic [15:0] rx_sample = 16'h0, tx_sample = 16'h0, tx_w, hi_cnt, rx_out, tx_out;
  logic [15:0] rxs [0:20];
  logic [15:0] txs [0:20];
  logic [15:0] cnt [0:19];
  logic awready, wready, bvalid, arready, rvalid, oe, dout, mon;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, lw;
  logic [7:0] r8;
  logic [31:0] exp_l [$];
  logic [33:0] exp_r [$];
  logic [1:0] exp_b [$];
  int fails = 0, n_tests = 0, fc = 4999, fn = -1, cyc = 0, nf;
  integer seed = 32'h88b4;

  cpm_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_sync(frame_sync), .bit_clock(bit_clock),
    .rx_sample(rx_sample), .tx_sample(tx_sample), .rx_line_out(rx_out),
    .tx_line_out(tx_out), .transmit_data_out(dout), .transmit_data_oe(oe),
    .monitor_analog_out(mon));
  cpm_spk_model spk (.aclk(aclk), .clr(clr), .drive(mon), .hi_cnt(hi_cnt));

  always #12.5 aclk = ~aclk;

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
          input logic [1:0] r);
    @(posedge aclk);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task at_end(input int n);
    while (!(fn == n && fc == 4900)) @(posedge aclk);
    cnt[n] = hi_cnt;
  endtask

  // Frame source: constant 5000-clock frames so the rate never drifts
  always @(posedge aclk) begin
    if (run) begin
      nf = (fc == 4999) ? 0 : fc + 1;
      fc <= nf;
      frame_sync <= nf < 2500;
      bit_clock <= nf < 3200 && nf % 200 >= 100;
      clr <= nf == 10;
      if (nf == 0) begin
        fn <= fn + 1;
        rx_sample <= rxs[fn+1];
        tx_sample <= txs[fn+1];
        exp_l.push_back({rxs[fn+1], txs[fn+1]});
      end
    end
  end

  // Result watcher: every answer takes the oldest note of its kind
  always @(posedge aclk) begin
    if (bvalid && bready) chk(34'(bresp), 34'(exp_b.pop_front()));
    if (rvalid && rready) chk({rresp, rdata}, exp_r.pop_front());
    if (run && fc == 50) begin
      lw = exp_l.pop_front();
      chk(34'({rx_out, tx_out}), 34'(lw));
      tx_w = lw[15:0];
    end
    if (run && fc == 150) chk(34'(oe), 34'h1);
    if (run && fc < 3200 && fc % 200 == 105)
      chk(34'(dout), 34'(tx_w[15 - (fc - 105) / 200]));
    if (run && fc == 3300) chk(34'(oe), 34'(!tri_q));
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 115000) begin
      fails++;
      print_verdict;
    end
  end

  initial begin
    for (int i = 0; i < 21; i++) begin
      rxs[i] = 16'($random(seed));
      txs[i] = 16'($random(seed));
    end
    // Known samples where the delay checks look back to them
    rxs[0] = 16'h0;
    rxs[1] = KA;
    rxs[2] = 16'h0;
    rxs[4] = 16'h0;
    rxs[5] = 16'h0;
    rxs[12] = 16'h0;
    rxs[13] = 16'h0;
    rxs[14] = KA;
    rxs[15] = KA;
    rxs[16] = KA << 1;
    rxs[17] = KA << 1;
    txs[17] = KA;
    r8 = 8'($random(seed));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_C1, {24'h0, cpm_pkg::CTRL_RESET}, cpm_pkg::RESP_OKAY);
    rd(A_C2, {24'h0, cpm_pkg::CTRL_RESET}, cpm_pkg::RESP_OKAY);
    rd(A_RX, {24'h0, cpm_pkg::ATT_RESET}, cpm_pkg::RESP_OKAY);
    rd(A_TX, {24'h0, cpm_pkg::ATT_RESET}, cpm_pkg::RESP_OKAY);
    rd(A_ST, 32'h0, cpm_pkg::RESP_OKAY);
    rd(8'h40, 32'h0, cpm_pkg::RESP_SLVERR);
    wr(8'h40, r8, 4'hf, cpm_pkg::RESP_SLVERR);
    wr(A_TX, r8, 4'hf, cpm_pkg::RESP_OKAY);
    wr(A_TX, ~r8, 4'he, cpm_pkg::RESP_OKAY);
    rd(A_TX, {24'h0, r8}, cpm_pkg::RESP_OKAY);
    $display("register tests done");
    wr(A_C2, 8'h00, 4'hf, cpm_pkg::RESP_OKAY);
    wr(A_RX, 8'h80, 4'hf, cpm_pkg::RESP_OKAY);
    wr(A_TX, 8'h00, 4'hf, cpm_pkg::RESP_OKAY);
    wr(A_C1, 8'h08, 4'hf, cpm_pkg::RESP_OKAY);
    run <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      at_end(n);
      case (n)
        2: begin
          wr(A_C1, 8'h0a, 4'hf, cpm_pkg::RESP_OKAY);
          tri_q <= 1'b1;
        end
        3: begin
          wr(A_C1, 8'h08, 4'hf, cpm_pkg::RESP_OKAY);
          tri_q <= 1'b0;
        end
        4: wr(A_C1, 8'h39, 4'hf, cpm_pkg::RESP_OKAY);
        5: wr(A_C1, 8'h19, 4'hf, cpm_pkg::RESP_OKAY);
        6: wr(A_C1, 8'h29, 4'hf, cpm_pkg::RESP_OKAY);
        7: wr(A_C1, 8'h00, 4'hf, cpm_pkg::RESP_OKAY);
        8: begin
          wr(A_C1, 8'h08, 4'hf, cpm_pkg::RESP_OKAY);
          wr(A_C2, 8'h80, 4'hf, cpm_pkg::RESP_OKAY);
        end
        9: wr(A_C2, 8'h00, 4'hf, cpm_pkg::RESP_OKAY);
        13: wr(A_C1, 8'h09, 4'hf, cpm_pkg::RESP_OKAY);
        16: wr(A_RX, 8'h00, 4'hf, cpm_pkg::RESP_OKAY);
        17: wr(A_RX, 8'h40, 4'hf, cpm_pkg::RESP_OKAY);
        18: begin
          wr(A_RX, 8'h00, 4'hf, cpm_pkg::RESP_OKAY);
          wr(A_TX, 8'h80, 4'hf, cpm_pkg::RESP_OKAY);
        end
        default: ;
      endcase
    end
    $display("frame tests done");
    chk(34'(cnt[5]), 34'h0);
    chk(34'(cnt[8]), 34'h0);
    chk(34'(cnt[9]), 34'h0);
    chk(34'(cnt[6] >= WIN / 2 - 1 && cnt[6] <= WIN / 2 + 2), 34'h1);
    chk(34'(cnt[7] >= WIN / 2 - BAL_TOL && cnt[7] <= WIN / 2 + BAL_TOL), 34'h1);
    chk(34'(cnt[17]), 34'(cnt[15]));
    chk(34'(cnt[12]), 34'(cnt[15]));
    chk(34'(cnt[13]), 34'(cnt[16]));
    chk(34'(cnt[14]), 34'(cnt[15]));
    chk(34'(cnt[16] !== cnt[15]), 34'h1);
    chk(34'(cnt[18]), 34'(cnt[16]));
    chk(34'(cnt[19]), 34'(cnt[16]));
    $display("monitor tests done");
    print_verdict;
  end
endmodule
